/* File: adc_port_pkg.sv */
/*
 * Shared constants and types for the converter control and read port
 * and its latchup guard. Assumes a 100 MHz reference clock; every
 * cycle count below is derived from a time in nanoseconds.
 */
package adc_port_pkg;

	localparam int DATA_W = 16;
	localparam int CNT_W = 12;

	localparam int CLK_PERIOD_NS = 10;

	// Times as specified, in nanoseconds
	localparam int CONV_TIME_NS = 7600;
	localparam int DATA_VALID_MAX_NS = 8000;
	localparam int BUSY_START_MAX_NS = 85;
	localparam int BUSY_TAIL_NS = 220;
	localparam int BUSY_AFTER_DATA_MIN_NS = 50;
	localparam int PREV_HOLD_NS = 7400;
	localparam int PROTECT_NS = 1000;
	localparam int RECOVER_NS = 25000;

	// Least times round up except PREV_HOLD_NS, longest times round down
	localparam logic [CNT_W-1:0] CONV_CYC =
		CNT_W'(CONV_TIME_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CONV_MAX_CYC =
		CNT_W'(DATA_VALID_MAX_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BUSY_START_MAX_CYC =
		CNT_W'(BUSY_START_MAX_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BUSY_TAIL_CYC =
		CNT_W'(BUSY_TAIL_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BUSY_AFTER_DATA_CYC =
		CNT_W'((BUSY_AFTER_DATA_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PREV_HOLD_CYC =
		CNT_W'(PREV_HOLD_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] PROTECT_CYC =
		CNT_W'((PROTECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RECOVER_CYC =
		CNT_W'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONV = 3'h2,
		ST_TAIL = 3'h4
	} conv_st_e;

	typedef enum logic [2:0] {
		GD_ON = 3'h1,
		GD_OFF = 3'h2,
		GD_RECOVER = 3'h4
	} guard_st_e;

endpackage : adc_port_pkg

/* File: guard_if.sv */
/*
 * Carrier between the read port and its latchup guard: the current
 * sensor trip, the core power switch and the status level.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface guard_if;
	logic trip;
	logic core_on;
	logic status;

	modport guard (
		input trip,
		output core_on,
		output status
	);

	modport core (
		output trip,
		input core_on,
		input status
	);
endinterface : guard_if

/* File: host_model.sv */
/*
 * Host controller model: drives chip select and read/convert from the
 * bench's requests. Assumes requests change just after a rising edge.
 */
`timescale 1ns/1ps
module host_model
#(
	parameter int FILT_CYC = 1200 // Quiet cycles before results count
)
(
	input wire logic clk, // Clock
	input wire logic rst, // Reset, active high
	input wire logic want_sel, // Bench asks for chip select
	input wire logic want_conv, // Bench holds convert line low
	input wire logic status, // Latchup status from the port
	output logic cs_n, // Chip select, active low
	output logic rc, // Read/convert line
	output logic trusted // Results may be used
);
	logic [11:0] quiet_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cs_n <= 1'b1;
			rc <= 1'b1;
			quiet_reg <= 12'h000;
		end
		else
		begin
			// Forced low, never left high, so the core is not backdriven
			cs_n <= ~want_sel & ~status;
			rc <= ~want_conv & ~status;
			// Any status bounce restarts the wait
			if (status)
				quiet_reg <= 12'h000;
			else if (quiet_reg != FILT_CYC[11:0])
				quiet_reg <= quiet_reg + 12'h001;
		end
	end
	assign trusted = (quiet_reg == FILT_CYC[11:0]);
endmodule : host_model

/* File: latchup_guard.sv */
/*
 * Latchup guard: on a supply-current trip it removes core power for
 * the protection time, restores it, and holds status high until the
 * recovery interval has passed. Assumes the trip input is synchronous.
 */
`timescale 1ns/1ps
module latchup_guard
	import adc_port_pkg::*;
(
	input wire logic clk, // Reference clock
	input wire logic rst, // Asynchronous reset, active high
	guard_if.guard g // Trip in, power and status out
);

	typedef struct packed {
		guard_st_e st;
		logic [CNT_W-1:0] cnt;
		logic core_on;
		logic status;
	} guard_s;

	guard_s s_reg;
	guard_s s_next;

	localparam int prot_cyc = int'(PROTECT_CYC);

	always_comb
	begin
		s_next = s_reg;
		case (s_reg.st)
			GD_ON:
			begin
				if (g.trip)
				begin
					s_next.st = GD_OFF;
					s_next.cnt = CNT_ZERO;
					s_next.core_on = 1'b0;
					s_next.status = 1'b1;
				end
			end
			GD_OFF:
			begin
				s_next.cnt = s_reg.cnt + CNT_ONE;
				if (s_reg.cnt == PROTECT_CYC - CNT_ONE)
				begin
					s_next.core_on = 1'b1;
					s_next.st = GD_RECOVER;
					s_next.cnt = CNT_ZERO;
				end
			end
			GD_RECOVER:
			begin
				s_next.cnt = s_reg.cnt + CNT_ONE;
				// Status stays up while the core settles, so the host
				// never sees the unstable fall
				if (g.trip)
				begin
					s_next.st = GD_OFF;
					s_next.cnt = CNT_ZERO;
					s_next.core_on = 1'b0;
				end
				else if (s_reg.cnt == RECOVER_CYC - CNT_ONE)
				begin
					s_next.status = 1'b0;
					s_next.st = GD_ON;
				end
			end
			default:
			begin
				s_next.st = GD_ON;
				s_next.cnt = CNT_ZERO;
				s_next.core_on = 1'b1;
				s_next.status = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_reg.st <= GD_ON;
			s_reg.cnt <= CNT_ZERO;
			s_reg.core_on <= 1'b1;
			s_reg.status <= 1'b0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign g.core_on = s_reg.core_on;
	assign g.status = s_reg.status;

	chk_core_off_time: assert property (@(posedge clk) disable iff (rst)
		$fell(s_reg.core_on) |-> ##[prot_cyc:prot_cyc] s_reg.core_on)
		else $error("core power not restored after protection time");

	chk_status_while_off: assert property (@(posedge clk) disable iff (rst)
		!s_reg.core_on |-> s_reg.status)
		else $error("core power off without status high");

	cov_power_cycle: cover property (@(posedge clk) disable iff (rst)
		$rose(s_reg.core_on) && s_reg.status);

endmodule : latchup_guard

/* File: sar_adc_convert_read_port.sv */
/*
 * Conversion control and 16-bit three-state read port of a sampling
 * successive-approximation converter, with its latchup guard.
 * Assumes all inputs are synchronous to REF_CLK and that the converter
 * core presents its digitised input as a two's-complement word.
 */
`timescale 1ns/1ps

// What this block does
// - Chip select high keeps bus high-impedance
// - Convert falling with select high starts, bus off
// - Convert falling with select low starts, bus off
// - Busy rising shows completed conversion on bus
// - Select falling with convert high drives result
// - Reads during conversion return previous result
// - Both low at busy rise restarts unacquired
// - Convert commands ignored while busy low
// - Busy falls within 85 ns of start
// - New result valid within 8 us
// - Previous result kept 7.6 us, at least 7.4 us
// - Busy rises 220 ns after conversion end
// - Busy rises at least 50 ns after data
// - Fixed 16-bit word, bit 15 most significant
// - Latchup trip cycles core power off, on
// - Status high while core power removed
module sar_adc_convert_read_port
	import adc_port_pkg::*;
(
	input wire logic REF_CLK, // 100 MHz clock
	input wire logic SYS_RST, // Asynchronous reset, active high
	input wire logic CHIP_SEL_N, // Chip select, active low
	input wire logic READ_CONV, // High reads, falling edge converts
	input wire logic [DATA_W-1:0] SAMPLE_CODE, // Core's digitised input
	input wire logic LATCHUP_SENSE, // Supply-current trip
	output logic BUSY_N, // Low while a conversion runs
	output logic [DATA_W-1:0] DATA_O, // Result word
	output logic DATA_OE, // High while the data bus is driven
	output logic LATCHUP_STATUS, // High while core power is cycled
	output logic CORE_PWR_ON // Core power switch
);

	typedef struct packed {
		conv_st_e st;
		logic [CNT_W-1:0] cnt;
		logic [DATA_W-1:0] held;
		logic [DATA_W-1:0] result;
		logic rc_prev;
		logic again;
		logic busy_n;
		logic oe;
		logic status;
		logic core_on;
	} port_s;

	port_s s_reg;
	port_s s_next;
	logic rc_fall;
	logic start_cmd;
	logic restart_cmd;

	guard_if g ();

	assign g.trip = LATCHUP_SENSE;

	latchup_guard guard_inst (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.g(g)
	);

	always_comb
	begin
		s_next = s_reg;
		s_next.rc_prev = READ_CONV;
		s_next.status = g.status;
		s_next.core_on = g.core_on;
		s_next.again = 1'b0;
		rc_fall = s_reg.rc_prev && !READ_CONV;
		start_cmd = 1'b0;
		restart_cmd = 1'b0;
		case (s_reg.st)
			ST_IDLE:
			begin
				s_next.busy_n = 1'b1;
				// Nothing starts while the core is unpowered
				if (!g.status)
				begin
					// Lines held low at busy rise force one more round
					if (s_reg.again)
					begin
						restart_cmd = 1'b1;
					end
					// Either select level: a falling convert line starts
					else if (rc_fall)
					begin
						start_cmd = 1'b1;
					end
				end
			end
			ST_CONV:
			begin
				// Convert edges fall through here untouched
				s_next.cnt = s_reg.cnt + CNT_ONE;
				if (s_reg.cnt == CONV_CYC - CNT_ONE)
				begin
					// Result replaces n-1 only at end of conversion
					s_next.result = s_reg.held;
					s_next.st = ST_TAIL;
					s_next.cnt = CNT_ZERO;
				end
			end
			ST_TAIL:
			begin
				s_next.cnt = s_reg.cnt + CNT_ONE;
				if (s_reg.cnt == BUSY_TAIL_CYC - CNT_ONE)
				begin
					s_next.busy_n = 1'b1;
					s_next.st = ST_IDLE;
					// Busy is shown high for one cycle before the restart
					if (!CHIP_SEL_N && !READ_CONV)
					begin
						s_next.again = 1'b1;
					end
				end
			end
			default:
			begin
				s_next.st = ST_IDLE;
				s_next.cnt = CNT_ZERO;
				s_next.busy_n = 1'b1;
			end
		endcase
		if (start_cmd || restart_cmd)
		begin
			s_next.st = ST_CONV;
			s_next.cnt = CNT_ZERO;
			s_next.busy_n = 1'b0;
			// A restart has had no acquisition, so the hold stage keeps
			// its old sample and the result is not a fresh one
			if (start_cmd)
			begin
				s_next.held = SAMPLE_CODE;
			end
		end
		// Bus follows select and convert; a start always releases it
		s_next.oe = !CHIP_SEL_N && READ_CONV;
		if (g.status)
		begin
			// Status high, core off or recovering: abandon the conversion and release the bus
			s_next.st = ST_IDLE;
			s_next.cnt = CNT_ZERO;
			s_next.busy_n = 1'b1;
			s_next.oe = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s_reg.st <= ST_IDLE;
			s_reg.cnt <= CNT_ZERO;
			s_reg.held <= RESULT_RESET;
			s_reg.result <= RESULT_RESET;
			s_reg.rc_prev <= 1'b1;
			s_reg.again <= 1'b0;
			s_reg.busy_n <= 1'b1;
			s_reg.oe <= 1'b0;
			s_reg.status <= 1'b0;
			s_reg.core_on <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign BUSY_N = s_reg.busy_n;
	assign DATA_O = s_reg.result;
	assign DATA_OE = s_reg.oe;
	assign LATCHUP_STATUS = s_reg.status;
	assign CORE_PWR_ON = s_reg.core_on;

	// Helper counters for spans too long for a repetition
	logic [CNT_W-1:0] since_start;
	logic [CNT_W-1:0] busy_low_cnt;

	always_ff @(posedge REF_CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			since_start <= CNT_ZERO;
			busy_low_cnt <= CNT_ZERO;
		end
		else
		begin
			if (start_cmd || restart_cmd)
				since_start <= CNT_ZERO;
			else if (since_start != {CNT_W{1'b1}})
				since_start <= since_start + CNT_ONE;
			if (s_reg.busy_n)
				busy_low_cnt <= CNT_ZERO;
			else if (busy_low_cnt != {CNT_W{1'b1}})
				busy_low_cnt <= busy_low_cnt + CNT_ONE;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);

	chk_hiz_when_deselected: assert property (
		CHIP_SEL_N |=> !DATA_OE)
		else $error("data bus driven while deselected");

	chk_start_releases_bus: assert property (
		start_cmd |=> !DATA_OE && !BUSY_N)
		else $error("bus driven or busy high after a start");

	chk_busy_falls_fast: assert property (
		rc_fall && s_reg.st == ST_IDLE && !g.status |=> !BUSY_N)
		else $error("busy did not fall one cycle after convert edge");

	chk_convert_ignored: assert property (
		rc_fall && s_reg.st == ST_CONV && !g.status
		&& s_reg.cnt != CONV_CYC - CNT_ONE
		|=> s_reg.cnt == $past(s_reg.cnt) + CNT_ONE)
		else $error("convert command restarted a running conversion");

	chk_data_before_busy: assert property (
		$changed(s_reg.result) |-> (!BUSY_N) [*5])
		else $error("busy rose too soon after new data");

	chk_result_in_time: assert property (
		busy_low_cnt <= CONV_MAX_CYC + BUSY_TAIL_CYC)
		else $error("conversion ran past its limit");

	chk_previous_held: assert property (
		$changed(s_reg.result) |-> since_start >= PREV_HOLD_CYC
		&& since_start <= CONV_MAX_CYC)
		else $error("result replaced outside its window");

	chk_read_shows_result: assert property (
		!CHIP_SEL_N && READ_CONV && !g.status |=> DATA_OE)
		else $error("read did not enable the bus");

	chk_status_on_trip: assert property (
		LATCHUP_SENSE && !g.status |-> ##2 LATCHUP_STATUS)
		else $error("status did not follow a latchup trip");

	chk_unacquired_restart: assert property (
		s_reg.st == ST_TAIL && s_reg.cnt == BUSY_TAIL_CYC - CNT_ONE
		&& !CHIP_SEL_N && !READ_CONV && !g.status && !LATCHUP_SENSE
		|=> BUSY_N ##1 (s_reg.st == ST_CONV && !BUSY_N
		&& $stable(s_reg.held)))
		else $error("both low at busy rise did not restart");

	chk_bus_off_on_start: assert property (
		rc_fall && !CHIP_SEL_N && s_reg.st == ST_IDLE && !g.status
		|=> !DATA_OE)
		else $error("bus still driven after a convert edge");

	chk_prev_kept: assert property (
		s_reg.st == ST_CONV && s_reg.cnt != CONV_CYC - CNT_ONE
		|=> $stable(DATA_O))
		else $error("result changed during a conversion");

	chk_busy_rise_at_tail: assert property (
		s_reg.st == ST_TAIL && s_reg.cnt == BUSY_TAIL_CYC - CNT_ONE
		&& !g.status |=> BUSY_N)
		else $error("busy did not rise at the end of the tail");

	chk_busy_low_in_tail: assert property (
		s_reg.st == ST_TAIL |-> !BUSY_N)
		else $error("busy high while the tail runs");

	chk_sample_taken: assert property (
		start_cmd |=> s_reg.held == $past(SAMPLE_CODE))
		else $error("start did not capture the sample word");

	chk_idle_in_latchup: assert property (
		g.status |=> BUSY_N && !DATA_OE)
		else $error("port active while core power is cycled");

	cov_full_conversion: cover property (
		$rose(BUSY_N) && !CHIP_SEL_N && READ_CONV);

	cov_read_during_conv: cover property (
		!BUSY_N && DATA_OE);

	cov_restart: cover property (
		restart_cmd);

	cov_latchup_abort: cover property (
		$rose(LATCHUP_STATUS) && $past(s_reg.st) != ST_IDLE);

endmodule : sar_adc_convert_read_port

/* File: sar_adc_convert_read_port_test.sv */
/*
 * Self-checking bench for the converter read port and its host model.
 * Assumes the handed-over timing: 100 MHz clock, registered outputs.
 */
`timescale 1ns/1ps
module sar_adc_convert_read_port_test;
	import adc_port_pkg::*;
	typedef struct packed {
		logic [DATA_W-1:0] code;
		logic sel;
		logic again;
	} row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic want_sel = 1'b0;
	logic want_conv = 1'b0;
	logic sense = 1'b0;
	logic [DATA_W-1:0] code = 16'h0000;
	logic [DATA_W-1:0] prev = 16'h0000;
	logic [DATA_W-1:0] dout;
	logic cs_n, rc, ok, busy_n, oe, status, pwr;
	int miscompares = 0;
	int n_tests = 0;
	int t;
	int t_data;
	row_s rows [4] = '{
		'{16'h7FFF, 1'b1, 1'b0}, '{16'h8000, 1'b0, 1'b1},
		'{16'h0001, 1'b1, 1'b1}, '{16'hFFFE, 1'b0, 1'b0}};

	always #5 clk = ~clk;

	host_model i_host (.clk(clk), .rst(rst), .want_sel(want_sel),
		.want_conv(want_conv), .status(status), .cs_n(cs_n), .rc(rc),
		.trusted(ok));
	sar_adc_convert_read_port i_dut (.REF_CLK(clk), .SYS_RST(rst),
		.CHIP_SEL_N(cs_n), .READ_CONV(rc), .SAMPLE_CODE(code),
		.LATCHUP_SENSE(sense), .BUSY_N(busy_n), .DATA_O(dout),
		.DATA_OE(oe), .LATCHUP_STATUS(status), .CORE_PWR_ON(pwr));

	task automatic conclude();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp, got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_le(input string what, input int lim, got);
		n_tests++;
		if (got > lim)
		begin
			miscompares++;
			$display("[FAIL] %s expected <=%0d seen %0d", what, lim, got);
		end
	endtask : chk_le

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wait_lvl(input logic lvl, input int lim);
		int n = 0;
		while (busy_n !== lvl)
		begin
			tick(1);
			n++;
			if (n > lim)
			begin
				miscompares++;
				$display("[FAIL] busy wait expected %0d seen %0d", lim, n);
				conclude();
			end
		end
		n_tests++;
	endtask : wait_lvl

	task automatic run_row(input row_s r);
		@(posedge clk);
		code <= r.code;
		want_sel <= r.sel;
		tick(3);
		t = 0;
		t_data = -1;
		while (busy_n !== 1'b1 || t < 20)
		begin
			@(posedge clk);
			// Pulse of five cycles, plus, for rows with again set, a retry mid-run that must be lost
			want_conv <= t < 5 || (r.again && t >= 100 && t < 105);
			#1;
			t++;
			if (t == 3)
				chk("bus off at start", 16'h0000, 16'(oe));
			if (t == 9)
				chk("busy low", 16'h0000, 16'(busy_n));
			if (t == 12)
				chk("bus enable", 16'(r.sel), 16'(oe));
			if ((t == 12 || t == 700) && r.sel)
				chk("previous word", prev, dout);
			if (t_data < 0 && dout === r.code)
				t_data = t;
			if (t > 820)
			begin
				miscompares++;
				$display("[FAIL] busy rise expected 800 seen %0d", t);
				conclude();
			end
		end
		chk_le("busy low length", 800, t);
		if (r.sel)
			chk_le("data before busy", t - 5, t_data);
		tick(3);
		chk("no restart", 16'h0001, 16'(busy_n));
		if (!r.sel)
		begin
			chk("bus off", 16'h0000, 16'(oe));
			@(posedge clk);
			want_sel <= 1'b1;
			tick(3);
		end
		chk("bus enable", 16'h0001, 16'(oe));
		chk("new word", r.code, dout);
		@(posedge clk);
		want_sel <= 1'b0;
		tick(3);
		chk("bus released", 16'h0000, 16'(oe));
		prev = r.code;
		$display("row %h done", r.code);
	endtask : run_row

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk("reset busy", 16'h0001, 16'(busy_n));
		chk("reset bus", 16'h0000, 16'(oe));
		chk("reset word", RESULT_RESET, dout);
		chk("reset guard", 16'h0001, {14'h0000, status, pwr});
		$display("reset done");
		foreach (rows[i])
			run_row(rows[i]);
		// Convert line held low across busy rise: sample must not refresh
		@(posedge clk);
		code <= 16'h1234;
		want_sel <= 1'b1;
		want_conv <= 1'b1;
		wait_lvl(1'b0, 10);
		@(posedge clk);
		code <= 16'h4321;
		wait_lvl(1'b1, 800);
		wait_lvl(1'b0, 3);
		@(posedge clk);
		want_conv <= 1'b0;
		wait_lvl(1'b1, 800);
		tick(2);
		chk("unacquired word", 16'h1234, dout);
		prev = 16'h1234;
		$display("unacquired restart done");
		@(posedge clk);
		want_conv <= 1'b1;
		repeat (5) @(posedge clk);
		want_conv <= 1'b0;
		repeat (40) @(posedge clk);
		sense <= 1'b1;
		@(posedge clk);
		sense <= 1'b0;
		tick(3);
		chk("guard trip", 16'h000A, {12'h000, status, pwr, busy_n, oe});
		tick(10);
		chk("host backs off", 16'h0000, {13'h0000, cs_n, rc, ok});
		tick(75);
		chk("power off", 16'h0000, 16'(pwr));
		tick(20);
		chk("power back", 16'h0001, 16'(pwr));
		tick(2480);
		chk("status held", 16'h0001, 16'(status));
		tick(20);
		chk("status clear", 16'h0002, {13'h0000, status, busy_n, ok});
		chk("word kept", prev, dout);
		$display("latchup done");
		run_row('{16'h2468, 1'b1, 1'b0});
		conclude();
	end
endmodule : sar_adc_convert_read_port_test
